// *** satb_regs.svh ***
// Register indices, field positions, reset values and timing counts
`ifndef SATB_REGS_SVH
`define SATB_REGS_SVH
`define SATB_IDX_CMD 6'h00
`define SATB_IDX_IDLE_CFG 6'h10
`define SATB_IDX_SNIFF_CFG 6'h11
`define SATB_IDX_THRESH 6'h14
`define SATB_IDX_BURST_CFG 6'h16
`define SATB_IDX_BURST_INT 6'h17
`define SATB_IDX_DATA_A 6'h2D
`define SATB_IDX_DATA_B 6'h2E
`define SATB_IDX_TARGET 6'h2F
`define SATB_IDX_STATUS 6'h30
`define SATB_IDLE_BURST_EN 1
`define SATB_SNIFF_CNT_HI 4
`define SATB_SNIFF_CNT_LO 3
`define SATB_BCFG_REP_HI 5
`define SATB_BCFG_REP_LO 4
`define SATB_BCFG_CHIPID 3
`define SATB_BCFG_INTADC 2
`define SATB_BCFG_EXTADC 1
`define SATB_BCFG_RES 0
`define SATB_BCFG_WMASK 8'h3F
`define SATB_CMD_IDLE 8'h04
`define SATB_RST_BYTE 8'h00
`define SATB_RST_THRESH 8'h80
`define SATB_SNIFF_CNT_100 9'h064
`define SATB_SNIFF_CNT_500 9'h1F4
`define SATB_CLK_KHZ 100000
`define SATB_RES_FAST_MS 50
`define SATB_RES_SLOW_MS 15000
`define SATB_GAP_UNIT_US 100
`define SATB_RESP_OKAY 2'h0
`define SATB_RESP_SLVERR 2'h2
`endif

// *** satb_pkg.sv ***
// Types shared by the sniff threshold and burst transmit logic
package satb_pkg;
  typedef struct packed {
    logic cycle_done;
    logic energy;
    logic id_found;
  } satb_sniff_evt_t;
  typedef struct packed {
    logic [7:0] msg;
    logic chip_id_en;
    logic int_adc_en;
    logic ext_adc_en;
  } satb_tx_req_t;
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_CONV,
    ST_SEND,
    ST_GAP
  } satb_state_t;
endpackage

// *** satb_lfsr.sv ***
// Random source for repeat gaps, seeded from the chip identifier
`timescale 1ns/1ns
module satb_lfsr import satb_pkg::*; #(
  parameter logic [7:0] SEED = 8'h5A
) (
  input wire logic aclk,
  input wire logic aresetn,
  output logic [7:0] rnd
);
  logic [15:0] lfsr_r;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lfsr_r <= {SEED, ~SEED};
    end else if (lfsr_r[0]) begin
      lfsr_r <= (lfsr_r >> 1) ^ 16'hB400;
    end else begin
      lfsr_r <= lfsr_r >> 1;
    end
  end
  assign rnd = lfsr_r[7:0];
endmodule

// *** satb_autothr.sv ***
// False wake-up counting and threshold adjust decision
`timescale 1ns/1ns
`include "satb_regs.svh"
module satb_autothr import satb_pkg::*; (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [1:0] count_sel,
  input wire logic [7:0] target,
  input wire satb_sniff_evt_t sniff_evt,
  output logic thr_up,
  output logic thr_down
);
  logic [8:0] period;
  logic [8:0] cyc_cnt_r;
  logic [8:0] fw_cnt_r;
  logic [8:0] fw_now;
  logic en;
  logic hit;
  logic period_end;
  logic up_r;
  logic down_r;
  assign en = |count_sel;
  always_comb begin
    case (count_sel)
      2'h2: period = `SATB_SNIFF_CNT_500;
      default: period = `SATB_SNIFF_CNT_100;
    endcase
  end
  assign hit = sniff_evt.cycle_done & sniff_evt.energy & ~sniff_evt.id_found;
  assign fw_now = fw_cnt_r + {8'h00, hit};
  assign period_end = en & sniff_evt.cycle_done & (cyc_cnt_r == period - 9'h001);
  always_ff @(posedge aclk) begin
    if (!aresetn || !en || period_end) begin
      cyc_cnt_r <= 9'h000;
      fw_cnt_r <= 9'h000;
    end else if (sniff_evt.cycle_done) begin
      cyc_cnt_r <= cyc_cnt_r + 9'h001;
      fw_cnt_r <= fw_now;
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      up_r <= 1'h0;
      down_r <= 1'h0;
    end else begin
      up_r <= 1'h0;
      down_r <= 1'h0;
      if (period_end) begin
        if (fw_now > {1'h0, target}) begin
          up_r <= 1'h1;
        end else if (fw_now < {1'h0, target}) begin
          down_r <= 1'h1;
        end
      end
    end
  end
  assign thr_up = up_r;
  assign thr_down = down_r;
  a_disabled_quiet: assert property (@(posedge aclk) disable iff (!aresetn)
    !en |=> !up_r && !down_r) else $error("adjust while disabled");
  a_false_hold: assert property (@(posedge aclk) disable iff (!aresetn)
    (sniff_evt.cycle_done && sniff_evt.id_found && !period_end) |=>
    fw_cnt_r == $past(fw_cnt_r)) else $error("found id counted as false");
  a_period_clear: assert property (@(posedge aclk) disable iff (!aresetn)
    period_end |=> cyc_cnt_r == 9'h000 && fw_cnt_r == 9'h000) else $error("no restart");
  a_equal_hold: assert property (@(posedge aclk) disable iff (!aresetn)
    (period_end && fw_now == {1'h0, target}) |=> !up_r && !down_r)
    else $error("adjust on equal count");
  a_up_decision: assert property (@(posedge aclk) disable iff (!aresetn)
    (period_end && fw_now > {1'h0, target}) |=> up_r && !down_r)
    else $error("missing raise");
endmodule

// *** satb_top.sv ***
// Sniff auto-threshold and burst transmit scheduler with AXI4-Lite registers
// Operation
// - Raise threshold at period end when false wake-ups exceed target
// - Lower threshold at period end when false wake-ups are below target
// - False wake-up means energy seen but identifier not found
// - Decide in order: period, target, greater test, then less test
// - Current threshold stays readable by the host at all times
// - Burst starts on idle command while burst enable bit is set
// - Send on interval expiry and immediately on trigger pin
// - Timer bursts send first message byte, pin bursts the second
// - Repeat field adds zero to three extra copies per burst
// - Repeats are spaced by random gaps seeded from chip identifier
// - Chip identifier select bit adds identifier to payload
// - Internal converter bit converts battery and temperature into payload
// - External converter bit converts both external inputs into payload
// - Resolution bit picks fifteen seconds or fifty milliseconds per count
// - Nonzero sniff count field enables automatic adjustment
// - Automatic adjustment overwrites the threshold register
`timescale 1ns/1ns
`include "satb_regs.svh"
module satb_top import satb_pkg::*; #(
  parameter logic [7:0] CHIP_ID = 8'h5A, // Arbitrary value
  parameter logic [7:0] THR_STEP = 8'h01,
  parameter logic [31:0] RES_FAST_CYC = 32'(64'(`SATB_RES_FAST_MS) * `SATB_CLK_KHZ),
  parameter logic [31:0] RES_SLOW_CYC = 32'(64'(`SATB_RES_SLOW_MS) * `SATB_CLK_KHZ),
  parameter logic [31:0] GAP_UNIT_CYC = 32'(64'(`SATB_GAP_UNIT_US) * `SATB_CLK_KHZ / 1000)
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [7:0] s_axi_araddr,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  input wire satb_sniff_evt_t sniff_evt,
  input wire logic burst_trigger_pin_n,
  input wire logic conv_done,
  input wire logic tx_done,
  output logic conv_int_req,
  output logic conv_ext_req,
  output logic tx_start,
  output satb_tx_req_t tx_req,
  output logic [7:0] energy_threshold,
  output logic burst_active
);
  logic awready_r;
  logic wready_r;
  logic bvalid_r;
  logic [1:0] bresp_r;
  logic arready_r;
  logic rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0] rresp_r;
  logic aw_got_r;
  logic w_got_r;
  logic [7:0] awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  logic wr_fire;
  logic wr_en;
  logic [5:0] wr_idx;
  logic [5:0] rd_idx;
  logic [7:0] cmd_r;
  logic [7:0] idle_cfg_r;
  logic [7:0] sniff_cfg_r;
  logic [7:0] thr_r;
  logic [7:0] burst_cfg_r;
  logic [7:0] burst_int_r;
  logic [7:0] data_a_r;
  logic [7:0] data_b_r;
  logic [7:0] target_r;
  logic thr_up;
  logic thr_down;
  logic [7:0] rnd;
  logic burst_active_r;
  logic cmd_wr;
  logic sync1_r;
  logic sync2_r;
  logic sync3_r;
  logic pin_lvl_r;
  logic pin_fall;
  logic [31:0] res_cnt_r;
  logic [31:0] res_lim;
  logic [7:0] int_cnt_r;
  logic res_tick;
  logic tmr_exp;
  logic tmr_pend_r;
  logic pin_pend_r;
  logic go;
  satb_state_t st_r;
  satb_tx_req_t tx_req_r;
  logic tx_start_r;
  logic conv_int_r;
  logic conv_ext_r;
  logic src_pin_r;
  logic [1:0] rep_left_r;
  logic [8:0] gap_units_r;
  logic [31:0] gap_cnt_r;
  logic [2:0] n_starts_r;
  logic [1:0] rep_total_r;

  function automatic logic mapped(input logic [5:0] idx);
    case (idx)
      `SATB_IDX_CMD, `SATB_IDX_IDLE_CFG, `SATB_IDX_SNIFF_CFG, `SATB_IDX_THRESH,
      `SATB_IDX_BURST_CFG, `SATB_IDX_BURST_INT, `SATB_IDX_DATA_A, `SATB_IDX_DATA_B,
      `SATB_IDX_TARGET, `SATB_IDX_STATUS: mapped = 1'h1;
      default: mapped = 1'h0;
    endcase
  endfunction

  // Write address and data, taken in either order
  assign wr_fire = aw_got_r & w_got_r & ~bvalid_r;
  assign wr_idx = awaddr_r[7:2];
  assign wr_en = wr_fire & wstrb_r[0] & mapped(wr_idx);
  assign rd_idx = s_axi_araddr[7:2];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_r <= 1'h0;
      aw_got_r <= 1'h0;
      awaddr_r <= 8'h00;
    end else if (s_axi_awvalid && awready_r) begin
      awready_r <= 1'h0;
      aw_got_r <= 1'h1;
      awaddr_r <= s_axi_awaddr;
    end else if (bvalid_r && s_axi_bready) begin
      aw_got_r <= 1'h0;
    end else if (!aw_got_r) begin
      awready_r <= 1'h1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wready_r <= 1'h0;
      w_got_r <= 1'h0;
      wdata_r <= 32'h0000_0000;
      wstrb_r <= 4'h0;
    end else if (s_axi_wvalid && wready_r) begin
      wready_r <= 1'h0;
      w_got_r <= 1'h1;
      wdata_r <= s_axi_wdata;
      wstrb_r <= s_axi_wstrb;
    end else if (bvalid_r && s_axi_bready) begin
      w_got_r <= 1'h0;
    end else if (!w_got_r) begin
      wready_r <= 1'h1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_r <= 1'h0;
      bresp_r <= `SATB_RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_r <= 1'h1;
      bresp_r <= mapped(wr_idx) ? `SATB_RESP_OKAY : `SATB_RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_r <= 1'h0;
    end
  end

  // Read channel, answer one cycle after the address is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_r <= 1'h0;
      rvalid_r <= 1'h0;
      rdata_r <= 32'h0000_0000;
      rresp_r <= `SATB_RESP_OKAY;
    end else if (s_axi_arvalid && arready_r) begin
      arready_r <= 1'h0;
      rvalid_r <= 1'h1;
      rresp_r <= mapped(rd_idx) ? `SATB_RESP_OKAY : `SATB_RESP_SLVERR;
      case (rd_idx)
        `SATB_IDX_CMD: rdata_r <= {24'h00_0000, cmd_r};
        `SATB_IDX_IDLE_CFG: rdata_r <= {24'h00_0000, idle_cfg_r};
        `SATB_IDX_SNIFF_CFG: rdata_r <= {24'h00_0000, sniff_cfg_r};
        `SATB_IDX_THRESH: rdata_r <= {24'h00_0000, thr_r};
        `SATB_IDX_BURST_CFG: rdata_r <= {24'h00_0000, burst_cfg_r};
        `SATB_IDX_BURST_INT: rdata_r <= {24'h00_0000, burst_int_r};
        `SATB_IDX_DATA_A: rdata_r <= {24'h00_0000, data_a_r};
        `SATB_IDX_DATA_B: rdata_r <= {24'h00_0000, data_b_r};
        `SATB_IDX_TARGET: rdata_r <= {24'h00_0000, target_r};
        `SATB_IDX_STATUS: rdata_r <= {30'h0000_0000, burst_active_r, st_r != ST_IDLE};
        default: rdata_r <= 32'h0000_0000;
      endcase
    end else if (rvalid_r && s_axi_rready) begin
      rvalid_r <= 1'h0;
      arready_r <= 1'h1;
    end else if (!rvalid_r) begin
      arready_r <= 1'h1;
    end
  end

  // Software configuration registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cmd_r <= `SATB_RST_BYTE;
      idle_cfg_r <= `SATB_RST_BYTE;
      sniff_cfg_r <= `SATB_RST_BYTE;
      burst_cfg_r <= `SATB_RST_BYTE;
      burst_int_r <= `SATB_RST_BYTE;
      data_a_r <= `SATB_RST_BYTE;
      data_b_r <= `SATB_RST_BYTE;
      target_r <= `SATB_RST_BYTE;
    end else if (wr_en) begin
      case (wr_idx)
        `SATB_IDX_CMD: cmd_r <= wdata_r[7:0];
        `SATB_IDX_IDLE_CFG: idle_cfg_r <= wdata_r[7:0];
        `SATB_IDX_SNIFF_CFG: sniff_cfg_r <= wdata_r[7:0];
        `SATB_IDX_BURST_CFG: burst_cfg_r <= wdata_r[7:0] & `SATB_BCFG_WMASK;
        `SATB_IDX_BURST_INT: burst_int_r <= wdata_r[7:0];
        `SATB_IDX_DATA_A: data_a_r <= wdata_r[7:0];
        `SATB_IDX_DATA_B: data_b_r <= wdata_r[7:0];
        `SATB_IDX_TARGET: target_r <= wdata_r[7:0];
        default: ;
      endcase
    end
  end

  satb_autothr u_autothr (
    .aclk(aclk),
    .aresetn(aresetn),
    .count_sel(sniff_cfg_r[`SATB_SNIFF_CNT_HI:`SATB_SNIFF_CNT_LO]),
    .target(target_r),
    .sniff_evt(sniff_evt),
    .thr_up(thr_up),
    .thr_down(thr_down)
  );

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      thr_r <= `SATB_RST_THRESH;
    end else if (thr_up) begin
      thr_r <= (thr_r > 8'hFF - THR_STEP) ? 8'hFF : 8'(thr_r + THR_STEP);
    end else if (thr_down) begin
      thr_r <= (thr_r < THR_STEP) ? 8'h00 : 8'(thr_r - THR_STEP);
    end else if (wr_en && wr_idx == `SATB_IDX_THRESH) begin
      thr_r <= wdata_r[7:0];
    end
  end

  assign cmd_wr = wr_en && wr_idx == `SATB_IDX_CMD;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      burst_active_r <= 1'h0;
    end else if (cmd_wr && wdata_r[7:0] == `SATB_CMD_IDLE
                 && idle_cfg_r[`SATB_IDLE_BURST_EN]) begin
      burst_active_r <= 1'h1;
    end else if (cmd_wr || !idle_cfg_r[`SATB_IDLE_BURST_EN]) begin
      burst_active_r <= 1'h0;
    end
  end

  // Trigger pin synchroniser and falling edge
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync1_r <= 1'h1;
      sync2_r <= 1'h1;
      sync3_r <= 1'h1;
      pin_lvl_r <= 1'h1;
    end else begin
      sync1_r <= burst_trigger_pin_n;
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
      if (sync2_r == sync3_r) begin
        pin_lvl_r <= sync3_r;
      end
    end
  end
  assign pin_fall = pin_lvl_r & ~sync2_r & ~sync3_r;

  assign res_lim = (burst_cfg_r[`SATB_BCFG_RES] ? RES_SLOW_CYC : RES_FAST_CYC) - 32'h1;
  assign res_tick = res_cnt_r >= res_lim;
  assign tmr_exp = burst_active_r & res_tick & (int_cnt_r >= burst_int_r);
  always_ff @(posedge aclk) begin
    if (!aresetn || !burst_active_r) begin
      res_cnt_r <= 32'h0000_0000;
      int_cnt_r <= 8'h00;
    end else if (res_tick) begin
      res_cnt_r <= 32'h0000_0000;
      int_cnt_r <= (int_cnt_r >= burst_int_r) ? 8'h00 : int_cnt_r + 8'h01;
    end else begin
      res_cnt_r <= res_cnt_r + 32'h1;
    end
  end

  assign go = (st_r == ST_IDLE) & (pin_pend_r | tmr_pend_r);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tmr_pend_r <= 1'h0;
      pin_pend_r <= 1'h0;
    end else begin
      tmr_pend_r <= burst_active_r & (tmr_exp | (tmr_pend_r & ~(go & ~pin_pend_r)));
      pin_pend_r <= burst_active_r & (pin_fall | (pin_pend_r & ~go));
    end
  end

  satb_lfsr #(
    .SEED(CHIP_ID)
  ) u_lfsr (
    .aclk(aclk),
    .aresetn(aresetn),
    .rnd(rnd)
  );

  // Burst sequencer
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r <= ST_IDLE;
      tx_req_r <= '0;
      tx_start_r <= 1'h0;
      conv_int_r <= 1'h0;
      conv_ext_r <= 1'h0;
      src_pin_r <= 1'h0;
      rep_left_r <= 2'h0;
      gap_units_r <= 9'h000;
      gap_cnt_r <= 32'h0000_0000;
    end else begin
      tx_start_r <= 1'h0;
      conv_int_r <= 1'h0;
      conv_ext_r <= 1'h0;
      unique case (st_r)
        ST_IDLE: begin
          if (go) begin
            src_pin_r <= pin_pend_r;
            tx_req_r.msg <= pin_pend_r ? data_b_r : data_a_r;
            tx_req_r.chip_id_en <= burst_cfg_r[`SATB_BCFG_CHIPID];
            tx_req_r.int_adc_en <= burst_cfg_r[`SATB_BCFG_INTADC];
            tx_req_r.ext_adc_en <= burst_cfg_r[`SATB_BCFG_EXTADC];
            rep_left_r <= burst_cfg_r[`SATB_BCFG_REP_HI:`SATB_BCFG_REP_LO];
            if (burst_cfg_r[`SATB_BCFG_INTADC] || burst_cfg_r[`SATB_BCFG_EXTADC]) begin
              conv_int_r <= burst_cfg_r[`SATB_BCFG_INTADC];
              conv_ext_r <= burst_cfg_r[`SATB_BCFG_EXTADC];
              st_r <= ST_CONV;
            end else begin
              tx_start_r <= 1'h1;
              st_r <= ST_SEND;
            end
          end
        end
        ST_CONV: begin
          if (conv_done) begin
            tx_start_r <= 1'h1;
            st_r <= ST_SEND;
          end
        end
        ST_SEND: begin
          if (tx_done && rep_left_r == 2'h0) begin
            st_r <= ST_IDLE;
          end else if (tx_done) begin
            rep_left_r <= rep_left_r - 2'h1;
            gap_units_r <= {1'h0, rnd} + 9'h001;
            gap_cnt_r <= 32'h0000_0000;
            st_r <= ST_GAP;
          end
        end
        ST_GAP: begin
          if (gap_cnt_r < GAP_UNIT_CYC - 32'h1) begin
            gap_cnt_r <= gap_cnt_r + 32'h1;
          end else if (gap_units_r == 9'h001) begin
            tx_start_r <= 1'h1;
            st_r <= ST_SEND;
          end else begin
            gap_cnt_r <= 32'h0000_0000;
            gap_units_r <= gap_units_r - 9'h001;
          end
        end
      endcase
    end
  end

  assign s_axi_awready = awready_r;
  assign s_axi_wready = wready_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_arready = arready_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;
  assign conv_int_req = conv_int_r;
  assign conv_ext_req = conv_ext_r;
  assign tx_start = tx_start_r;
  assign tx_req = tx_req_r;
  assign energy_threshold = thr_r;
  assign burst_active = burst_active_r;

  // Copies sent within one burst
  always_ff @(posedge aclk) begin
    if (!aresetn || go) begin
      n_starts_r <= 3'h0;
      rep_total_r <= go ? burst_cfg_r[`SATB_BCFG_REP_HI:`SATB_BCFG_REP_LO] : 2'h0;
    end else if (tx_start_r) begin
      n_starts_r <= n_starts_r + 3'h1;
    end
  end

  a_thr_rise: assert property (@(posedge aclk) disable iff (!aresetn)
    (thr_up && thr_r <= 8'hFF - THR_STEP) |=> thr_r == 8'($past(thr_r) + THR_STEP))
    else $error("threshold not raised");
  a_thr_fall: assert property (@(posedge aclk) disable iff (!aresetn)
    (thr_down && thr_r >= THR_STEP) |=> thr_r == 8'($past(thr_r) - THR_STEP))
    else $error("threshold not lowered");
  a_burst_arm: assert property (@(posedge aclk) disable iff (!aresetn)
    (cmd_wr && wdata_r[7:0] == `SATB_CMD_IDLE && idle_cfg_r[`SATB_IDLE_BURST_EN])
    |=> burst_active_r) else $error("idle command did not arm burst");
  a_pin_request: assert property (@(posedge aclk) disable iff (!aresetn)
    (burst_active_r && idle_cfg_r[`SATB_IDLE_BURST_EN] && !cmd_wr && pin_fall)
    |=> pin_pend_r) else $error("trigger pin lost");
  a_msg_select: assert property (@(posedge aclk) disable iff (!aresetn)
    go |=> tx_req_r.msg == ($past(pin_pend_r) ? $past(data_b_r) : $past(data_a_r)))
    else $error("wrong message byte");
  a_repeat_count: assert property (@(posedge aclk) disable iff (!aresetn)
    (st_r == ST_SEND && tx_done && rep_left_r == 2'h0)
    |-> n_starts_r == {1'h0, rep_total_r} + 3'h1) else $error("wrong copy count");
  a_gap_follow: assert property (@(posedge aclk) disable iff (!aresetn)
    (st_r == ST_SEND && tx_done && rep_left_r != 2'h0)
    |=> st_r == ST_GAP ##1 !tx_start_r) else $error("repeat without gap");
  a_payload_flags: assert property (@(posedge aclk) disable iff (!aresetn)
    go |=> tx_req_r.chip_id_en == $past(burst_cfg_r[`SATB_BCFG_CHIPID])
    && conv_int_r == $past(burst_cfg_r[`SATB_BCFG_INTADC])
    && conv_ext_r == $past(burst_cfg_r[`SATB_BCFG_EXTADC])) else $error("payload flags");
  a_res_bound: assert property (@(posedge aclk) disable iff (!aresetn)
    burst_active_r && $stable(burst_cfg_r[`SATB_BCFG_RES])
    |-> res_cnt_r <= (burst_cfg_r[`SATB_BCFG_RES] ? RES_SLOW_CYC
    : RES_FAST_CYC)) else $error("resolution count overrun");
  a_reserved_zero: assert property (@(posedge aclk) disable iff (!aresetn)
    burst_cfg_r[7:6] == 2'h0) else $error("reserved bits stored");
  c_pin_burst: cover property (@(posedge aclk) disable iff (!aresetn)
    go && pin_pend_r ##[1:20] tx_start_r);
  c_repeat_gap: cover property (@(posedge aclk) disable iff (!aresetn)
    st_r == ST_GAP ##[1:300] tx_start_r);
  c_thr_move: cover property (@(posedge aclk) disable iff (!aresetn) thr_up or thr_down);
endmodule

// *** satb_radio_model.sv ***
// Converter and transmitter model answering the burst sequencer
`timescale 1ns/1ns
module satb_radio_model import satb_pkg::*; #(
  parameter int DLY = 5
) (
  input wire logic aclk,
  input wire logic conv_int_req,
  input wire logic conv_ext_req,
  input wire logic tx_start,
  input wire satb_tx_req_t tx_req,
  output logic conv_done = 1'b0,
  output logic tx_done = 1'b0,
  output logic [7:0] n_tx = 8'h00,
  output logic [7:0] n_int = 8'h00,
  output logic [7:0] n_ext = 8'h00,
  output logic [7:0] msg = 8'h00
);
  int cc = 0;
  int tc = 0;
  // Answers after a fixed delay, done only after a start
  always @(posedge aclk) begin
    cc <= (conv_int_req | conv_ext_req) ? DLY : (cc > 0 ? cc - 1 : 0);
    conv_done <= (cc == 1);
    tc <= tx_start ? DLY : (tc > 0 ? tc - 1 : 0);
    tx_done <= (tc == 1);
    n_int <= n_int + 8'(conv_int_req);
    n_ext <= n_ext + 8'(conv_ext_req);
    n_tx <= n_tx + 8'(tx_start);
    if (tx_start) begin
      msg <= tx_req.msg;
    end
  end
endmodule

// *** sniff_autothreshold_burst_tx_tb.sv ***
// Register-level bench for the sniff threshold and burst logic
`timescale 1ns/1ns
`include "satb_regs.svh"
module sniff_autothreshold_burst_tx_tb import satb_pkg::*; ;
  logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0;
  logic arvalid = 0, rready = 0, pin_n = 1;
  logic awready, wready, bvalid, arready, rvalid, cdone, tdone, ci, ce, txs, act;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00, thr, n_tx, n_int, n_ext, msg, rv, en;
  logic [31:0] wdata = 32'h0, rdata;
  logic [3:0] strb = 4'hF;
  logic [1:0] bresp, rresp, rs;
  satb_sniff_evt_t evt = '0;
  satb_tx_req_t txr;
  int fails = 0, comparisons = 0;
  initial forever #5 aclk = ~aclk;
  satb_top #(.RES_FAST_CYC(20), .RES_SLOW_CYC(50), .GAP_UNIT_CYC(4)) dut_u (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_awaddr(awaddr), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_wdata(wdata), .s_axi_wstrb(strb), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_bresp(bresp), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_araddr(araddr), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .sniff_evt(evt),
    .burst_trigger_pin_n(pin_n), .conv_done(cdone), .tx_done(tdone),
    .conv_int_req(ci), .conv_ext_req(ce), .tx_start(txs), .tx_req(txr),
    .energy_threshold(thr), .burst_active(act));
  satb_radio_model m_u (.aclk(aclk), .conv_int_req(ci), .conv_ext_req(ce),
    .tx_start(txs), .tx_req(txr), .conv_done(cdone), .tx_done(tdone),
    .n_tx(n_tx), .n_int(n_int), .n_ext(n_ext), .msg(msg));
  task automatic chk(input logic [31:0] s, input logic [31:0] e, input string nm);
    comparisons++;
    if (s !== e) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic wr(input logic [5:0] i, input logic [7:0] d);
    logic a, w;
    a = 0;
    w = 0;
    @(posedge aclk);
    awvalid <= 1;
    wvalid <= 1;
    awaddr <= {i, 2'b00};
    wdata <= {24'h000000, d};
    bready <= 1;
    while (!(a && w)) begin
      @(posedge aclk);
      a = a | awready;
      w = w | wready;
      awvalid <= !a;
      wvalid <= !w;
    end
    do @(posedge aclk); while (!bvalid);
    rs = bresp;
    bready <= 0;
  endtask
  task automatic rd(input logic [5:0] i);
    @(posedge aclk);
    arvalid <= 1;
    araddr <= {i, 2'b00};
    rready <= 1;
    do @(posedge aclk); while (!arready);
    arvalid <= 0;
    do @(posedge aclk); while (!rvalid);
    rv = rdata[7:0];
    rs = rresp;
    rready <= 0;
  endtask
  task automatic period(input int nf, input int nt, input int n);
    for (int k = 0; k < n; k++) begin
      @(posedge aclk);
      evt <= '{1'b1, k < nf + nt, k >= nf && k < nf + nt};
      @(posedge aclk);
      evt <= '0;
    end
    repeat (4) @(posedge aclk);
  endtask
  task automatic thr_is(input logic [7:0] e);
    rd(`SATB_IDX_THRESH);
    chk(rv, e, "thresh reg");
    chk(thr, e, "thresh out");
  endtask
  task automatic waittx(input logic [7:0] n);
    int k;
    k = 0;
    while (n_tx < n && k < 20000) begin
      @(posedge aclk);
      k++;
    end
    chk(k < 20000, 1'b1, "tx wait");
  endtask
  task automatic results();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  initial begin
    #500000;
    fails++;
    results();
  end
  initial begin
    repeat (3) @(posedge aclk);
    aresetn <= 1;
    @(posedge aclk);
    thr_is(8'h80);
    wr(6'h3F, 8'h01);
    chk(rs, `SATB_RESP_SLVERR, "unmapped");
    rd(6'h3F);
    chk(rs, `SATB_RESP_SLVERR, "unmapped rd");
    period(5, 0, 100);
    thr_is(8'h80);
    wr(`SATB_IDX_TARGET, 8'h02);
    strb <= 4'h0;
    wr(`SATB_IDX_TARGET, 8'h55);
    chk(rs, `SATB_RESP_OKAY, "strobe off resp");
    strb <= 4'hF;
    rd(`SATB_IDX_TARGET);
    chk(rv, 8'h02, "strobe off");
    wr(`SATB_IDX_SNIFF_CFG, 8'h08);
    period(3, 5, 100);
    thr_is(8'h81);
    period(2, 5, 100);
    thr_is(8'h81);
    period(1, 0, 100);
    thr_is(8'h80);
    wr(`SATB_IDX_SNIFF_CFG, 8'h10);
    period(3, 0, 100);
    thr_is(8'h80);
    period(0, 0, 400);
    thr_is(8'h81);
    wr(`SATB_IDX_SNIFF_CFG, 8'h18);
    period(3, 0, 100);
    thr_is(8'h82);
    $display("threshold test done");
    wr(`SATB_IDX_DATA_A, 8'h11);
    wr(`SATB_IDX_DATA_B, 8'h22);
    wr(`SATB_IDX_BURST_INT, 8'hFF);
    wr(`SATB_IDX_IDLE_CFG, 8'h02);
    wr(`SATB_IDX_CMD, `SATB_CMD_IDLE);
    repeat (2) @(posedge aclk);
    chk(act, 1'b1, "armed");
    rd(`SATB_IDX_STATUS);
    chk(rv, 8'h02, "status");
    en = 8'h00;
    for (int r = 0; r < 4; r++) begin
      wr(`SATB_IDX_BURST_CFG, 8'hCF | 8'(r << 4));
      pin_n <= 0;
      en = en + 8'(r + 1);
      waittx(en);
      pin_n <= 1;
      repeat (1100) @(posedge aclk);
      chk(n_tx, en, "copies");
    end
    rd(`SATB_IDX_BURST_CFG);
    chk(rv, 8'h3F, "burst cfg");
    chk(msg, 8'h22, "pin msg");
    chk({txr.chip_id_en, txr.int_adc_en, txr.ext_adc_en}, 3'b111, "payload");
    chk({n_int, n_ext}, 16'h0404, "conversions");
    waittx(en + 8'h01);
    chk(msg, 8'h11, "timer msg");
    $display("burst test done");
    wr(`SATB_IDX_CMD, 8'h00);
    repeat (4000) @(posedge aclk);
    chk(act, 1'b0, "disarmed");
    pin_n <= 0;
    repeat (40) @(posedge aclk);
    pin_n <= 1;
    chk(n_tx, en + 8'h04, "idle tx");
    $display("disarm test done");
    results();
  end
endmodule
